/* File: ifi_core.sv */
// Implementation choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps

module ifi_core
(
    input  wire logic                        clk_sys_in,       // 40 MHz system clock
    input  wire logic                        reset_in,         // synchronous, active high
    input  wire logic [ifi_pkg::WORD_W-1:0]  instr_in,         // instruction word of this cycle
    input  wire logic                        instr_valid_in,   // word presented at Q1
    input  wire logic                        next_two_word_in, // fetched next word is two-word
    input  wire logic [ifi_pkg::DATA_W-1:0]  file_rdata_in,    // file data, valid at Q2
    input  wire logic [3:0]                  reg_addr_in,      // register port address
    input  wire logic [7:0]                  reg_wdata_in,     // register write data
    input  wire logic                        reg_write_in,     // register write strobe
    input  wire logic                        reg_read_in,      // register read strobe
    output logic [7:0]                       reg_rdata_out,    // read data, cycle after strobe
    output logic [ifi_pkg::ADDR_W-1:0]       file_addr_out,    // file register address
    output ifi_pkg::ifi_file_write_type      file_write_out,   // write to file, set at Q4, high during the next Q1
    output logic [1:0]                       phase_out,        // current Q phase 0..3
    output logic                             busy_out          // flushing a skipped word
);

    function automatic logic is_ours(input logic [5:0] op);
        is_ours = (op == ifi_pkg::OP_INCREMENT) || (op == ifi_pkg::OP_INC_SKIP_Z)
                  || (op == ifi_pkg::OP_INC_SKIP_NZ);
    endfunction

    // software-visible state
    logic                       extended_en;
    logic [ifi_pkg::BANK_W-1:0] bank_select_register;
    logic [ifi_pkg::ADDR_W-1:0] index_base;
    logic [ifi_pkg::DATA_W-1:0] working;
    ifi_pkg::ifi_flags_type     flags;
    logic [7:0]                 reg_rdata;

    logic                       next_extended_en;
    logic [ifi_pkg::BANK_W-1:0] next_bank_select_register;
    logic [ifi_pkg::ADDR_W-1:0] next_index_base;
    logic [ifi_pkg::DATA_W-1:0] next_working;
    ifi_pkg::ifi_flags_type     next_flags;
    logic [7:0]                 next_reg_rdata;

    // execution state
    ifi_pkg::ifi_state_type     state;
    ifi_pkg::ifi_state_type     next_state;
    logic [1:0]                 phase;
    logic [1:0]                 next_phase;
    logic [ifi_pkg::WORD_W-1:0] instr;
    logic [ifi_pkg::WORD_W-1:0] next_instr;
    logic                       active;
    logic                       next_active;
    logic [ifi_pkg::DATA_W-1:0] operand;
    logic [ifi_pkg::DATA_W-1:0] next_operand;
    logic [ifi_pkg::ADDR_W-1:0] file_addr;
    logic [ifi_pkg::ADDR_W-1:0] next_file_addr;
    ifi_pkg::ifi_file_write_type file_write;
    ifi_pkg::ifi_file_write_type next_file_write;
    logic                       two_word;
    logic                       next_two_word;
    logic                       busy;
    logic                       next_busy;

    logic [5:0]                 op;
    logic [7:0]                 f_field;
    logic [ifi_pkg::ADDR_W-1:0] decoded_addr;
    logic [ifi_pkg::DATA_W:0]   sum;
    logic [4:0]                 low_sum;
    logic [ifi_pkg::DATA_W-1:0] result;
    logic                       do_skip;

    assign op      = instr_in[ifi_pkg::OP_MSB:ifi_pkg::OP_LSB];
    assign f_field = instr_in[7:0];
    assign sum     = {1'b0, operand} + 9'h001;
    assign low_sum = {1'b0, operand[3:0]} + 5'h01;
    assign result  = sum[ifi_pkg::DATA_W-1:0];
    assign do_skip = (instr[ifi_pkg::OP_MSB:ifi_pkg::OP_LSB] == ifi_pkg::OP_INC_SKIP_Z)
                         ? (result == ifi_pkg::BYTE_RESET)
                         : (instr[ifi_pkg::OP_MSB:ifi_pkg::OP_LSB] == ifi_pkg::OP_INC_SKIP_NZ)
                             && (result != ifi_pkg::BYTE_RESET);

    always_comb
    begin
        if (!instr_in[ifi_pkg::BANK_BIT])
        begin
            if (extended_en && (f_field <= ifi_pkg::INDEXED_LIMIT))
            begin
                decoded_addr = index_base + {4'h0, f_field};
            end
            else if (f_field < ifi_pkg::FAST_SPLIT)
            begin
                decoded_addr = {4'h0, f_field};
            end
            else
            begin
                decoded_addr = {ifi_pkg::FAST_HIGH_BANK, f_field};
            end
        end
        else
        begin
            decoded_addr = {bank_select_register, f_field};
        end
    end

    // register port
    always_comb
    begin
        next_extended_en          = extended_en;
        next_bank_select_register = bank_select_register;
        next_index_base           = index_base;
        next_reg_rdata            = 8'h00;
        if (reg_write_in)
        begin
            unique case (reg_addr_in)
                ifi_pkg::REG_CONTROL:     next_extended_en = reg_wdata_in[0];
                ifi_pkg::REG_BANK_SELECT: next_bank_select_register = reg_wdata_in[3:0];
                ifi_pkg::REG_INDEX_BASE:  next_index_base = {4'h0, reg_wdata_in};
                default:                  next_extended_en = extended_en;
            endcase
        end
        if (reg_read_in)
        begin
            unique case (reg_addr_in)
                ifi_pkg::REG_CONTROL:     next_reg_rdata = {7'h00, extended_en};
                ifi_pkg::REG_BANK_SELECT: next_reg_rdata = {4'h0, bank_select_register};
                ifi_pkg::REG_INDEX_BASE:  next_reg_rdata = index_base[7:0];
                ifi_pkg::REG_WORKING:     next_reg_rdata = working;
                ifi_pkg::REG_FLAGS:       next_reg_rdata = {3'h0, flags};
                ifi_pkg::REG_STATUS:      next_reg_rdata = {5'h00, busy_out, phase};
                default:                  next_reg_rdata = 8'h00;
            endcase
        end
    end

    // execution: Q1 decode, Q2 read, Q3 process, Q4 write
    always_comb
    begin
        next_state      = state;
        next_phase      = phase + 2'h1;
        next_instr      = instr;
        next_active     = active;
        next_operand    = operand;
        next_file_addr  = file_addr;
        next_file_write = '0;
        next_two_word   = two_word;
        next_working    = working;
        next_flags      = flags;
        unique case (phase)
            ifi_pkg::PHASE_Q1:
            begin
                next_active = (state == ifi_pkg::IFI_EXEC) && instr_valid_in && is_ours(op);
                if (state == ifi_pkg::IFI_EXEC)
                begin
                    next_instr     = instr_in;
                    next_file_addr = decoded_addr;
                end
            end
            2'h1:
            begin
                next_operand = file_rdata_in;
            end
            2'h2:
            begin
                next_operand = operand;
            end
            ifi_pkg::PHASE_Q4:
            begin
                if (active)
                begin
                    if (instr[ifi_pkg::DEST_BIT])
                    begin
                        next_file_write = '{1'b1, file_addr, result};
                    end
                    else
                    begin
                        next_working = result;
                    end
                    if (instr[ifi_pkg::OP_MSB:ifi_pkg::OP_LSB] == ifi_pkg::OP_INCREMENT)
                    begin
                        next_flags.carry       = sum[ifi_pkg::DATA_W];
                        next_flags.digit_carry = low_sum[4];
                        next_flags.zero        = (result == ifi_pkg::BYTE_RESET);
                        next_flags.negative    = result[7];
                        next_flags.overflow    = (operand == 8'h7F);
                    end
                    if (do_skip)
                    begin
                        next_state    = ifi_pkg::IFI_FLUSH;
                        next_two_word = next_two_word_in;
                    end
                end
                else if (state == ifi_pkg::IFI_FLUSH)
                begin
                    // skipped word executes as a no-operation
                    next_state = two_word ? ifi_pkg::IFI_FLUSH_SECOND
                                          : ifi_pkg::IFI_EXEC;
                end
                else
                begin
                    next_state = ifi_pkg::IFI_EXEC;
                end
                next_active = 1'b0;
            end
        endcase
        // registered so the busy pin comes straight from a flop
        next_busy = (next_state != ifi_pkg::IFI_EXEC);
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (reset_in)
        begin
            extended_en          <= 1'b0;
            bank_select_register <= '0;
            index_base           <= '0;
            working              <= ifi_pkg::BYTE_RESET;
            flags                <= '0;
            reg_rdata            <= 8'h00;
            state                <= ifi_pkg::IFI_EXEC;
            phase                <= ifi_pkg::PHASE_RESET;
            instr                <= '0;
            active               <= 1'b0;
            operand              <= ifi_pkg::BYTE_RESET;
            file_addr            <= '0;
            file_write           <= '0;
            two_word             <= 1'b0;
            busy                 <= 1'b0;
        end
        else
        begin
            extended_en          <= next_extended_en;
            bank_select_register <= next_bank_select_register;
            index_base           <= next_index_base;
            working              <= next_working;
            flags                <= next_flags;
            reg_rdata            <= next_reg_rdata;
            state                <= next_state;
            phase                <= next_phase;
            instr                <= next_instr;
            active               <= next_active;
            operand              <= next_operand;
            file_addr            <= next_file_addr;
            file_write           <= next_file_write;
            two_word             <= next_two_word;
            busy                 <= next_busy;
        end
    end

    assign reg_rdata_out  = reg_rdata;
    assign file_addr_out  = file_addr;
    assign file_write_out = file_write;
    assign phase_out      = phase;
    assign busy_out       = busy;

endmodule

/* File: ifi_pkg.sv */
package ifi_pkg;

    localparam int DATA_W = 8;
    localparam int WORD_W = 16;
    localparam int BANK_W = 4;
    localparam int ADDR_W = 12;

    // opcode fields, word[15:10]
    localparam logic [5:0] OP_INCREMENT    = 6'h0A;
    localparam logic [5:0] OP_INC_SKIP_Z   = 6'h0F;
    localparam logic [5:0] OP_INC_SKIP_NZ  = 6'h12;
    localparam int         OP_MSB          = 15;
    localparam int         OP_LSB          = 10;
    localparam int         DEST_BIT        = 9;
    localparam int         BANK_BIT        = 8;

    localparam logic [7:0] INDEXED_LIMIT   = 8'h5F;
    localparam logic [7:0] FAST_SPLIT      = 8'h80;
    localparam logic [3:0] FAST_HIGH_BANK  = 4'hF;
    localparam logic [7:0] ALL_ONES        = 8'hFF;

    // register addresses of the bus port
    localparam logic [3:0] REG_CONTROL     = 4'h0;
    localparam logic [3:0] REG_BANK_SELECT = 4'h1;
    localparam logic [3:0] REG_INDEX_BASE  = 4'h2;
    localparam logic [3:0] REG_WORKING     = 4'h3;
    localparam logic [3:0] REG_FLAGS       = 4'h4;
    localparam logic [3:0] REG_STATUS      = 4'h5;

    localparam logic [1:0] PHASE_Q1        = 2'h0;
    localparam logic [1:0] PHASE_Q4        = 2'h3;
    localparam logic [1:0] PHASE_RESET     = 2'h0;
    localparam logic [7:0] BYTE_RESET      = 8'h00;

    typedef struct packed {
        logic carry;
        logic digit_carry;
        logic zero;
        logic overflow;
        logic negative;
    } ifi_flags_type;

    typedef struct packed {
        logic              write_en;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } ifi_file_write_type;

    typedef enum logic [1:0] {
        IFI_EXEC,
        IFI_FLUSH,
        IFI_FLUSH_SECOND
    } ifi_state_type;

endpackage

/* File: ifi_core_chk.sv */
`timescale 1ns/1ps

module ifi_core_chk
(
    input wire logic                       clk_sys_in,     // system clock
    input wire logic                       reset_in,       // synchronous reset
    input wire logic [ifi_pkg::WORD_W-1:0] instr_in,       // instruction word
    input wire logic [ifi_pkg::DATA_W-1:0] file_rdata_in,  // file read data
    input wire logic [ifi_pkg::ADDR_W-1:0] file_addr_out,  // file address
    input wire ifi_pkg::ifi_file_write_type file_write_out, // file write
    input wire logic [1:0]                 phase_out,      // q phase
    input wire logic                       busy_out        // flushing
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (reset_in);

    // a flushed word occupies one whole four-phase cycle
    sequence s_flush_cycle;
        busy_out [*4];
    endsequence

    sequence s_write_now;
        file_write_out.write_en;
    endsequence

    AST_PHASE_STEP: assert property (!$past(reset_in) |-> phase_out == $past(phase_out) + 2'h1)
        else $error("phase did not advance by one");
    AST_WRITE_AT_Q1: assert property (s_write_now |-> phase_out == ifi_pkg::PHASE_Q1)
        else $error("file write outside the first phase");
    AST_WRITE_PULSE: assert property (s_write_now |=> !file_write_out.write_en)
        else $error("file write longer than one cycle");
    AST_WRITE_ADDR: assert property (s_write_now |-> file_write_out.addr == file_addr_out)
        else $error("file write to another address than read");
    AST_WRITE_DATA: assert property (s_write_now |-> file_write_out.data == $past(file_rdata_in, 3) + 8'h01)
        else $error("file write data is not operand plus one");
    AST_WRITE_DEST: assert property (s_write_now |-> $past(instr_in[ifi_pkg::DEST_BIT], 4))
        else $error("file written with destination bit clear");
    AST_ADDR_LATCH: assert property (!$stable(file_addr_out) |-> phase_out == 2'h1)
        else $error("file address moved outside the decode edge");
    AST_BUSY_START: assert property ($rose(busy_out) |-> phase_out == ifi_pkg::PHASE_Q1)
        else $error("flush began mid cycle");
    AST_BUSY_HOLD: assert property ($rose(busy_out) |-> s_flush_cycle ##[1:5] !busy_out)
        else $error("flush length wrong");
    AST_FLUSH_NOP: assert property (busy_out && $past(busy_out) |-> !file_write_out.write_en)
        else $error("skipped word wrote a file register");
endmodule

bind ifi_core ifi_core_chk u_ifi_core_chk
(
    .clk_sys_in, .reset_in, .instr_in, .file_rdata_in,
    .file_addr_out, .file_write_out, .phase_out, .busy_out
);

/* File: tb_ifi_core.sv */
`timescale 1ns/1ps

module tb_ifi_core;
    localparam logic [3:0] BANK_SEL   = 4'h3;
    localparam logic [7:0] INDEX_BASE = 8'h20;
    logic                        clk_sys_in       = 1'b0;
    logic                        reset_in         = 1'b1;
    logic [ifi_pkg::WORD_W-1:0]  instr_in         = 16'h0000;
    logic                        instr_valid_in   = 1'b0;
    logic                        next_two_word_in = 1'b0;
    logic [ifi_pkg::DATA_W-1:0]  file_rdata_in    = 8'h00;
    logic [3:0]                  reg_addr_in      = 4'h0;
    logic [7:0]                  reg_wdata_in     = 8'h00;
    logic                        reg_write_in     = 1'b0;
    logic                        reg_read_in      = 1'b0;
    logic [7:0]                  reg_rdata_out;
    logic [ifi_pkg::ADDR_W-1:0]  file_addr_out;
    ifi_pkg::ifi_file_write_type file_write_out;
    logic [1:0]                  phase_out;
    logic                        busy_out;
    logic [7:0]                  exp_w = 8'h00;
    logic [7:0]                  exp_f = 8'h00;
    int                          failures = 0;
    int                          comparisons = 0;
    int                          cycles = 0;

    ifi_core u_ifi_core
    (
        .clk_sys_in, .reset_in, .instr_in, .instr_valid_in, .next_two_word_in,
        .file_rdata_in, .reg_addr_in, .reg_wdata_in, .reg_write_in, .reg_read_in,
        .reg_rdata_out, .file_addr_out, .file_write_out, .phase_out, .busy_out
    );

    always #12.5 clk_sys_in = ~clk_sys_in;

    task automatic tally_and_finish();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // about 25 cycles per instruction; a hang is cut well past that
    always @(posedge clk_sys_in)
    begin
        cycles <= cycles + 1;
        if (cycles == 2000)
        begin
            failures++;
            tally_and_finish();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            failures++;
            $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_write_in <= 1'b1;
        @(posedge clk_sys_in);
        reg_write_in <= 1'b0;
    endtask

    // phase is looked at between edges, then we return on the edge that ends Q4
    task automatic to_q4_edge();
        do
            @(negedge clk_sys_in);
        while (phase_out !== ifi_pkg::PHASE_Q4);
        @(posedge clk_sys_in);
    endtask

    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk_sys_in);
        reg_addr_in <= a;
        reg_read_in <= 1'b1;
        @(posedge clk_sys_in);
        reg_read_in <= 1'b0;
        #1;
        check(16'(reg_rdata_out), 16'(e));
    endtask

    task automatic step(input logic [5:0] op, input logic d, input logic a, input logic [7:0] f,
                        input logic [7:0] rv, input logic ext, input logic tw);
        logic [7:0]  res;
        logic [11:0] ea;
        logic        ours;
        logic        skp;
        res = rv + 8'h01;
        ours = op == ifi_pkg::OP_INCREMENT || op == ifi_pkg::OP_INC_SKIP_Z
               || op == ifi_pkg::OP_INC_SKIP_NZ;
        skp = (op == ifi_pkg::OP_INC_SKIP_Z && res == 8'h00)
              || (op == ifi_pkg::OP_INC_SKIP_NZ && res != 8'h00);
        if (a)
            ea = {BANK_SEL, f};
        else if (ext && f <= ifi_pkg::INDEXED_LIMIT)
            ea = {4'h0, INDEX_BASE} + {4'h0, f};
        else
            ea = {(f < ifi_pkg::FAST_SPLIT) ? 4'h0 : ifi_pkg::FAST_HIGH_BANK, f};
        wr(ifi_pkg::REG_CONTROL, {7'h00, ext});
        to_q4_edge();
        instr_in <= {op, d, a, f};
        instr_valid_in <= 1'b1;
        next_two_word_in <= tw;
        file_rdata_in <= rv;
        @(posedge clk_sys_in);
        // a skipped word stays offered so the flush must refuse it
        instr_valid_in <= skp;
        #1;
        if (ours)
            check(16'(file_addr_out), 16'(ea));
        check(16'(phase_out), 16'h0001);
        to_q4_edge();
        #1;
        check(16'(file_write_out.write_en), 16'(ours && d));
        if (ours && d)
            check({file_write_out.addr, 4'h0}, {ea, 4'h0});
        if (ours && d)
            check(16'(file_write_out.data), 16'(res));
        check(16'(busy_out), 16'(skp));
        repeat (3) @(posedge clk_sys_in);
        instr_valid_in <= 1'b0;
        @(posedge clk_sys_in);
        #1;
        check(16'(file_write_out.write_en), 16'h0000);
        check(16'(busy_out), 16'(skp && tw));
        repeat (4) @(posedge clk_sys_in);
        #1;
        check(16'(busy_out), 16'h0000);
        if (ours && !d)
            exp_w = res;
        if (op == ifi_pkg::OP_INCREMENT)
            exp_f = {3'h0, rv == 8'hFF, rv[3:0] == 4'hF, res == 8'h00, rv == 8'h7F, res[7]};
        rd(ifi_pkg::REG_STATUS, 8'h01);
        rd(ifi_pkg::REG_WORKING, exp_w);
        rd(ifi_pkg::REG_FLAGS, exp_f);
    endtask

    initial
    begin
        repeat (6) @(posedge clk_sys_in);
        reset_in <= 1'b0;
        for (int i = 0; i < 5; i++)
            rd(4'(i), 8'h00);
        rd(4'hF, 8'h00);
        wr(ifi_pkg::REG_BANK_SELECT, {4'h0, BANK_SEL});
        wr(ifi_pkg::REG_INDEX_BASE, INDEX_BASE);
        rd(ifi_pkg::REG_BANK_SELECT, {4'h0, BANK_SEL});
        $display("test registers done");
        step(ifi_pkg::OP_INCREMENT, 1'b1, 1'b0, 8'h10, 8'hFF, 1'b0, 1'b0);
        step(ifi_pkg::OP_INCREMENT, 1'b0, 1'b1, 8'h22, 8'h7F, 1'b0, 1'b0);
        step(ifi_pkg::OP_INCREMENT, 1'b1, 1'b0, 8'h90, 8'h05, 1'b0, 1'b0);
        step(ifi_pkg::OP_INCREMENT, 1'b0, 1'b0, 8'h5F, 8'h0E, 1'b1, 1'b0);
        step(ifi_pkg::OP_INCREMENT, 1'b1, 1'b0, 8'h60, 8'h0F, 1'b1, 1'b0);
        $display("test increment done");
        step(ifi_pkg::OP_INC_SKIP_Z, 1'b1, 1'b1, 8'h01, 8'hFF, 1'b0, 1'b0);
        step(ifi_pkg::OP_INC_SKIP_Z, 1'b0, 1'b1, 8'h02, 8'h10, 1'b0, 1'b0);
        step(ifi_pkg::OP_INC_SKIP_NZ, 1'b1, 1'b0, 8'h30, 8'h10, 1'b0, 1'b1);
        step(ifi_pkg::OP_INC_SKIP_NZ, 1'b0, 1'b0, 8'h31, 8'hFF, 1'b0, 1'b1);
        $display("test skip done");
        step(6'h00, 1'b1, 1'b0, 8'h10, 8'h33, 1'b0, 1'b0);
        $display("test foreign opcode done");
        tally_and_finish();
    end
endmodule
